// *** logic/dual_controller_bus_interface.sv ***
// processor bus interface: path select, phases, dma and buffer layout
`timescale 1ns/1ps
`include "bus_if_map.svh"

// Contract
// - A1 low host, high peripheral
// - command phase then data phase, A0 selects
// - registers by PIO, buffers by PIO or DMA
// - chip select active: decode A1, ignore acks
// - chip select idle: ignore A1, serve DMA
// - ack without own request is ignored
// - both requests and acks: interface off
// - DMA drives bus by ack, else none
// - host areas packed from zero in order
// - interrupt/async areas split into equal blocks
// - iso next header rounds to four bytes
// - peripheral sixteen areas, no direct addressing
// - all endpoints configured before allocation
// - four processor locations reach everything
// - channel one host, channel two peripheral
// - internal end-of-transfer stops DMA
// - command index in lower byte
// - 32-bit access: one command, two data
// - read strobe data only; command write-only
module dual_controller_bus_interface (
   input wire logic i_clk, // 125 MHz clock
   input wire logic i_rst_n, // async reset, active low
   input wire logic i_ce, // clock enable, freezes all state
   input wire bus_if_pkg::pin_bus_t i_pins, // processor pins, asynchronous
   input wire logic [15:0] i_data, // data bus input
   output logic [15:0] o_data, // data bus output value
   output logic o_data_oe, // data bus output enable
   input wire logic i_host_dma_want, // host side wants a dma transfer
   input wire logic i_periph_dma_want, // peripheral side wants a dma transfer
   input wire logic [15:0] i_host_dma_bytes, // host dma byte count
   input wire logic [15:0] i_periph_dma_bytes, // peripheral dma byte count
   output logic o_host_dma_request, // channel one request pin
   output logic o_periph_dma_request, // channel two request pin
   output logic o_end_of_transfer, // one-cycle pulse, dma ended
   input wire logic [15:0] i_host_rdata, // host controller read data
   input wire logic [15:0] i_periph_rdata, // peripheral read data
   output bus_if_pkg::reg_req_t o_req, // access details
   output logic o_cmd_strobe, // pulse, command index taken
   output logic o_wr_strobe, // pulse, data word written
   output logic o_rd_strobe, // pulse, data word read
   output bus_if_pkg::path_t o_path, // current bus owner
   input wire logic [12:0] i_iso_area_size, // each iso area, bytes
   input wire logic [12:0] i_interrupt_area_size, // interrupt area, bytes
   input wire logic [12:0] i_async_area_size, // async area, bytes
   input wire logic [10:0] i_interrupt_block_size, // payload per block
   input wire logic [10:0] i_async_block_size, // payload per block
   input wire logic [4:0] i_block_sel, // block number to locate
   output logic [12:0] o_iso_list_b_start, // second iso area start
   output logic [12:0] o_interrupt_list_start, // interrupt area start
   output logic [12:0] o_async_list_start, // async area start
   output logic [12:0] o_unused_start, // first unused byte
   output logic [12:0] o_interrupt_block_addr, // selected block header
   output logic [12:0] o_async_block_addr, // selected block header
   input wire logic [12:0] i_iso_hdr_addr, // current iso header address
   input wire logic [9:0] i_iso_total_size, // its payload size
   output logic [12:0] o_iso_next_hdr, // next iso header address
   input wire logic [15:0] i_ep_configured, // endpoint area configured
   input wire logic [15:0][9:0] i_ep_size, // endpoint area sizes
   output logic o_periph_alloc_ok, // peripheral buffer may be laid out
   input wire logic i_direct_mode // software selected direct addressing
);
   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   bus_if_pkg::pin_bus_t pin_s1_q;
   bus_if_pkg::pin_bus_t pin_s2_q;
   bus_if_pkg::pin_bus_t pin_d3_q;
   logic [15:0] data_s1_q;
   logic [15:0] data_s2_q;

   // two flops on every pin; third copy only for edge detection
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pin_s1_q <= 7'h7F;
         pin_s2_q <= 7'h7F;
         pin_d3_q <= 7'h7F;
         data_s1_q <= 16'h0000;
         data_s2_q <= 16'h0000;
      end else if (i_ce) begin
         pin_s1_q <= i_pins;
         pin_s2_q <= pin_s1_q;
         pin_d3_q <= pin_s2_q;
         data_s1_q <= i_data;
         data_s2_q <= data_s1_q;
      end
   end

   // ----------------------------------------------------------------
   // path selection
   // ----------------------------------------------------------------
   logic [1:0] req_q;
   logic cs_act;
   logic ack1;
   logic ack2;
   logic pio_host;
   logic pio_periph;
   logic dma_host;
   logic dma_periph;
   logic bus_off;
   bus_if_pkg::path_t path_w;

   assign cs_act = ~pin_s2_q.cs_n;
   assign ack1 = ~pin_s2_q.host_dma_ack_n;
   assign ack2 = ~pin_s2_q.periph_dma_ack_n;
   // chip select wins; acks are not even looked at then
   assign pio_host = cs_act & ~pin_s2_q.a1;
   assign pio_periph = cs_act & pin_s2_q.a1;
   // a1 is ignored here; an ack counts only with its own request
   assign dma_host = ~cs_act & ack1 & req_q[0];
   assign dma_periph = ~cs_act & ack2 & req_q[1];
   // both channels fully handshaking at once is a hazard: back off
   assign bus_off = ~cs_act & (&req_q) & ack1 & ack2;
   assign path_w = bus_off ? bus_if_pkg::PATH_OFF :
                   pio_host ? bus_if_pkg::PATH_HOST :
                   pio_periph ? bus_if_pkg::PATH_PERIPH :
                   dma_host ? bus_if_pkg::PATH_HOST :
                   dma_periph ? bus_if_pkg::PATH_PERIPH :
                   bus_if_pkg::PATH_NONE;

   // ----------------------------------------------------------------
   // strobe decode
   // ----------------------------------------------------------------
   logic rd_fall;
   logic wr_fall;
   logic is_dma;
   logic is_periph;
   logic sel_ok;
   logic cmd_wr;
   logic data_wr;
   logic data_rd;
   assign rd_fall = pin_d3_q.rd_n & ~pin_s2_q.rd_n;
   assign wr_fall = pin_d3_q.wr_n & ~pin_s2_q.wr_n;
   assign is_dma = ~cs_act;
   assign is_periph = (path_w == bus_if_pkg::PATH_PERIPH);
   assign sel_ok = (path_w == bus_if_pkg::PATH_HOST) | is_periph;
   // four pio locations plus dma; commands are pio writes with a0 high
   assign cmd_wr = wr_fall & cs_act & pin_s2_q.a0;
   // dma never reaches registers: it is always a buffer data phase
   assign data_wr = wr_fall & sel_ok & (is_dma | ~pin_s2_q.a0);
   // reads of a command port are ignored
   assign data_rd = rd_fall & sel_ok & (is_dma | ~pin_s2_q.a0);

   // ----------------------------------------------------------------
   // command and data phases
   // ----------------------------------------------------------------
   bus_if_pkg::reg_req_t req_q_s;
   logic cmd_stb_q;
   logic wr_stb_q;
   logic rd_stb_q;
   logic hi_q;
   logic eot_q;
   logic [1:0] eot_w;

   // the index byte is kept; later data phases alternate low/high word
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         req_q_s <= '0;
         cmd_stb_q <= 1'b0;
         wr_stb_q <= 1'b0;
         rd_stb_q <= 1'b0;
         hi_q <= 1'b0;
         eot_q <= 1'b0;
      end else if (i_ce) begin
         cmd_stb_q <= cmd_wr;
         wr_stb_q <= data_wr;
         rd_stb_q <= data_rd;
         eot_q <= |eot_w; // one pulse for either channel's last word
         if (cmd_wr) begin
            // upper byte is zero by protocol and not kept
            req_q_s.cmd_index <= data_s2_q[`CMD_INDEX_MSB:`CMD_INDEX_LSB];
            req_q_s.periph <= pin_s2_q.a1;
            req_q_s.dma <= 1'b0;
            req_q_s.hi_word <= 1'b0;
            hi_q <= 1'b0;
         end else if (data_wr | data_rd) begin
            req_q_s.wdata <= data_s2_q;
            req_q_s.periph <= is_periph;
            req_q_s.dma <= is_dma;
            req_q_s.hi_word <= hi_q;
            hi_q <= ~hi_q;
         end
      end
   end

   // ----------------------------------------------------------------
   // data bus drive
   // ----------------------------------------------------------------
   logic [15:0] data_q;
   logic oe_q;
   bus_if_pkg::path_t path_q;
   logic drive;
   // only a selected data read drives; off or idle leaves the bus open
   assign drive = ~pin_s2_q.rd_n & sel_ok & (is_dma | ~pin_s2_q.a0);

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         data_q <= 16'h0000;
         oe_q <= 1'b0;
         path_q <= bus_if_pkg::PATH_NONE;
      end else if (i_ce) begin
         oe_q <= drive;
         data_q <= is_periph ? i_periph_rdata : i_host_rdata;
         path_q <= path_w;
      end
   end

   // ----------------------------------------------------------------
   // dma channels: request and end of transfer
   // ----------------------------------------------------------------
   // bit 0 is channel one (host buffer), bit 1 channel two (peripheral)
   logic [1:0] want;
   logic [1:0] word_done;
   logic [1:0] done_q;
   logic [15:0] bytes_in [2];
   logic [15:0] cnt_q [2];
   assign want = {i_periph_dma_want, i_host_dma_want};
   assign word_done = {dma_periph, dma_host} & {2{data_wr | data_rd}};
   assign bytes_in[0] = i_host_dma_bytes;
   assign bytes_in[1] = i_periph_dma_bytes;

   // the external controller paces words; the count decides the end
   for (genvar c = 0; c < 2; c++) begin : g_chan
      assign eot_w[c] = word_done[c] & (cnt_q[c] <= `DMA_WORD_BYTES);
      always_ff @(posedge i_clk or negedge i_rst_n) begin
         if (!i_rst_n) begin
            req_q[c] <= 1'b0;
            done_q[c] <= 1'b0;
            cnt_q[c] <= 16'h0000;
         end else if (i_ce) begin
            if (!want[c]) begin
               done_q[c] <= 1'b0;
               req_q[c] <= 1'b0;
            end else if (!req_q[c] && !done_q[c]) begin
               req_q[c] <= 1'b1;
               cnt_q[c] <= bytes_in[c];
            end else if (eot_w[c]) begin
               req_q[c] <= 1'b0;
               done_q[c] <= 1'b1;
            end else if (word_done[c]) begin
               cnt_q[c] <= cnt_q[c] - `DMA_WORD_BYTES;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // host buffer layout
   // ----------------------------------------------------------------
   logic [12:0] iso_b_w;
   logic [12:0] int_w;
   logic [12:0] async_w;
   logic [12:0] unused_w;
   logic [16:0] int_off;
   logic [16:0] async_off;
   logic [12:0] iso_pad;
   // starts follow the sizes combinationally, so any change takes effect
   assign iso_b_w = i_iso_area_size;
   assign int_w = 13'(iso_b_w + i_iso_area_size);
   assign async_w = 13'(int_w + i_interrupt_area_size);
   assign unused_w = 13'(async_w + i_async_area_size);
   // each block holds header plus fixed payload
   assign int_off = 17'(i_block_sel) * 17'(13'(i_interrupt_block_size) + `DESC_HDR_BYTES);
   assign async_off = 17'(i_block_sel) * 17'(13'(i_async_block_size) + `DESC_HDR_BYTES);
   // payload padded up to a double-word boundary
   assign iso_pad = 13'((14'(i_iso_total_size) + 14'h0003) & 14'h3FFC);

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_iso_list_b_start <= 13'h0000;
         o_interrupt_list_start <= 13'h0000;
         o_async_list_start <= 13'h0000;
         o_unused_start <= 13'h0000;
         o_interrupt_block_addr <= 13'h0000;
         o_async_block_addr <= 13'h0000;
         o_iso_next_hdr <= 13'h0000;
      end else if (i_ce) begin
         o_iso_list_b_start <= iso_b_w;
         o_interrupt_list_start <= int_w;
         o_async_list_start <= async_w;
         o_unused_start <= unused_w;
         o_interrupt_block_addr <= 13'(int_w + int_off[12:0]);
         o_async_block_addr <= 13'(async_w + async_off[12:0]);
         o_iso_next_hdr <= 13'(i_iso_hdr_addr + `DESC_HDR_BYTES + iso_pad);
      end
   end

   // ----------------------------------------------------------------
   // peripheral buffer allocation gate
   // ----------------------------------------------------------------
   logic [15:0] ep_ok;
   logic alloc_ok_q;
   // fixed control areas need no size check; others must be in range
   for (genvar e = 0; e < 16; e++) begin : g_ep
      if (e < `EP_FIXED) begin : g_fixed
         assign ep_ok[e] = i_ep_configured[e];
      end else begin : g_prog
         assign ep_ok[e] = i_ep_configured[e] & (i_ep_size[e] >= `EP_MIN_BYTES) &
                           (i_ep_size[e] <= `EP_MAX_BYTES);
      end
   end

   // direct addressing has no meaning for the peripheral buffer
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         alloc_ok_q <= 1'b0;
      end else if (i_ce) begin
         alloc_ok_q <= (&ep_ok) & ~i_direct_mode;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign o_data = data_q;
   assign o_data_oe = oe_q;
   assign o_host_dma_request = req_q[0];
   assign o_periph_dma_request = req_q[1];
   assign o_end_of_transfer = eot_q;
   assign o_req = req_q_s;
   assign o_cmd_strobe = cmd_stb_q;
   assign o_wr_strobe = wr_stb_q;
   assign o_rd_strobe = rd_stb_q;
   assign o_path = path_q;
   assign o_periph_alloc_ok = alloc_ok_q;
endmodule

// *** logic/bus_if_map.svh ***
// constants of the processor-side bus interface
`ifndef BUS_IF_MAP_SVH
`define BUS_IF_MAP_SVH
`define HOST_MEM_BYTES 13'h1000
`define PERIPH_MEM_BYTES 12'h099E
`define DESC_HDR_BYTES 13'h0008
`define MAX_LIST_BLOCKS 6'h20
`define EP_AREAS 5'h10
`define EP_FIXED 5'h02
`define EP_MIN_BYTES 10'h010
`define EP_MAX_BYTES 10'h3FF
`define CMD_INDEX_LSB 0
`define CMD_INDEX_MSB 7
`define DMA_WORD_BYTES 16'h0002
`endif

// *** logic/bus_if_pkg.sv ***
// types shared by the processor-side bus interface
package bus_if_pkg;
   // raw processor pins, all active levels as on the wire
   typedef struct packed {
      logic cs_n;
      logic a1;
      logic a0;
      logic rd_n;
      logic wr_n;
      logic host_dma_ack_n;
      logic periph_dma_ack_n;
   } pin_bus_t;

   // one access handed to the internal controllers
   typedef struct packed {
      logic [7:0] cmd_index;
      logic [15:0] wdata;
      logic periph;
      logic dma;
      logic hi_word;
   } reg_req_t;

   // which controller owns the data bus
   typedef enum logic [3:0] {
      PATH_NONE = 4'b0001,
      PATH_HOST = 4'b0010,
      PATH_PERIPH = 4'b0100,
      PATH_OFF = 4'b1000
   } path_t;
endpackage

// *** bench/bus_if_sva.sv ***
// checker for the processor bus interface outputs
`timescale 1ns/1ps
module bus_if_sva (
   input wire logic i_clk, // clock
   input wire logic i_rst_n, // reset, active low
   input wire logic [12:0] i_iso_area_size, // iso area bytes
   input wire logic [12:0] i_interrupt_area_size, // interrupt area bytes
   input wire logic [12:0] i_async_area_size, // async area bytes
   input wire logic [12:0] i_iso_hdr_addr, // iso header
   input wire logic [9:0] i_iso_total_size, // iso payload
   input wire logic o_data_oe, // bus drive
   input wire bus_if_pkg::path_t o_path, // bus owner
   input wire logic o_host_dma_request, // channel one
   input wire logic o_periph_dma_request, // channel two
   input wire logic o_end_of_transfer, // end pulse
   input wire logic o_cmd_strobe, // command taken
   input wire bus_if_pkg::reg_req_t o_req, // access details
   input wire logic [12:0] o_interrupt_list_start, // area start
   input wire logic [12:0] o_unused_start, // first unused byte
   input wire logic [12:0] o_iso_next_hdr // next header
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   // ----------------------------------------
   // helper and properties
   // ----------------------------------------
   // layout checks wait one edge after reset, since $past still sees reset-time inputs
   logic up_q;
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) up_q <= 1'b0;
      else up_q <= 1'b1;
   end
   property p_off_quiet;
      o_path == bus_if_pkg::PATH_OFF && $past(o_path) == bus_if_pkg::PATH_OFF |-> !o_data_oe;
   endproperty
   a_off_quiet: assert property (p_off_quiet) else $error("bus driven while off");
   property p_none_quiet;
      o_path == bus_if_pkg::PATH_NONE && $past(o_path) == bus_if_pkg::PATH_NONE |-> !o_data_oe;
   endproperty
   a_none_quiet: assert property (p_none_quiet) else $error("bus driven unselected");
   property p_off_cause;
      o_path == bus_if_pkg::PATH_OFF |-> $past(o_host_dma_request) && $past(o_periph_dma_request);
   endproperty
   a_off_cause: assert property (p_off_cause) else $error("off without both requests");
   property p_interrupt_list_start;
      up_q |-> o_interrupt_list_start == 13'($past(i_iso_area_size) << 1);
   endproperty
   a_interrupt_list_start: assert property (p_interrupt_list_start) else $error("interrupt start wrong");
   property p_unused_start;
      up_q |-> o_unused_start == 13'(($past(i_iso_area_size) << 1) + $past(i_interrupt_area_size)
         + $past(i_async_area_size));
   endproperty
   a_unused_start: assert property (p_unused_start) else $error("unused start wrong");
   property p_iso_next;
      up_q |-> o_iso_next_hdr == 13'($past(i_iso_hdr_addr) + 13'h0008
         + ((13'($past(i_iso_total_size)) + 13'h0003) & ~13'h0003));
   endproperty
   a_iso_next: assert property (p_iso_next) else $error("iso next header wrong");
   property p_eot_cause;
      o_end_of_transfer |-> ($past(o_host_dma_request, 2) && !o_host_dma_request)
         || ($past(o_periph_dma_request, 2) && !o_periph_dma_request);
   endproperty
   a_eot_cause: assert property (p_eot_cause) else $error("end pulse without request drop");
   property p_eot_pulse;
      o_end_of_transfer |=> !o_end_of_transfer;
   endproperty
   a_eot_pulse: assert property (p_eot_pulse) else $error("end pulse too long");
   property p_cmd_low_word;
      o_cmd_strobe |-> !o_req.hi_word && !o_req.dma;
   endproperty
   a_cmd_low_word: assert property (p_cmd_low_word) else $error("command not reset");
   c_eot: cover property (o_end_of_transfer);
   c_off: cover property (o_path == bus_if_pkg::PATH_OFF);
   c_cmd: cover property (o_cmd_strobe);
endmodule
bind dual_controller_bus_interface bus_if_sva i_bus_if_sva (.i_clk, .i_rst_n, .i_iso_area_size,
   .i_interrupt_area_size, .i_async_area_size, .i_iso_hdr_addr, .i_iso_total_size, .o_data_oe,
   .o_path, .o_host_dma_request, .o_periph_dma_request, .o_end_of_transfer, .o_cmd_strobe,
   .o_req, .o_interrupt_list_start, .o_unused_start, .o_iso_next_hdr);

// *** bench/cpu_dma_model.sv ***
// model of the processor and its dma controller on the pin side
`timescale 1ns/1ps
module cpu_dma_model (
   input wire logic i_clk, // clock
   input wire logic [15:0] i_dev_data, // device drive value
   input wire logic i_dev_oe, // device drives the bus
   output bus_if_pkg::pin_bus_t o_pins, // processor pins
   output logic [15:0] o_bus // resolved data bus
);
   logic [15:0] drv_q = 16'h0000;
   logic drv_on = 1'b0;
   initial o_pins = '1;
   // a released bus shows the inverse of the last word, never a stale copy
   assign o_bus = i_dev_oe ? i_dev_data : (drv_on ? drv_q : ~drv_q);
   // one word: strobe low four clocks, high four, so the synchroniser sees both levels
   task automatic access(input logic cs_n, a1, a0, rd, ackh, ackp, input logic [15:0] d);
      @(posedge i_clk);
      o_pins <= {cs_n, a1, a0, !rd, rd, ackh, ackp};
      drv_q <= d;
      drv_on <= !rd;
      repeat (4) @(posedge i_clk);
      o_pins.rd_n <= 1'b1;
      o_pins.wr_n <= 1'b1;
      repeat (4) @(posedge i_clk);
      o_pins <= '1;
      drv_on <= 1'b0;
   endtask
endmodule

// *** bench/dual_controller_bus_interface_test.sv ***
// self-checking bench for the processor bus interface
`timescale 1ns/1ps
module dual_controller_bus_interface_test;
   logic i_clk = 1'b0, i_rst_n = 1'b0, i_ce = 1'b1, i_direct_mode = 1'b0;
   logic i_host_dma_want = 1'b0, i_periph_dma_want = 1'b0;
   logic [15:0] i_host_dma_bytes = '0, i_periph_dma_bytes = '0, i_ep_configured = '0;
   logic [15:0] i_host_rdata = '0, i_periph_rdata = '0, i_data, o_data, rd_val;
   logic [12:0] i_iso_area_size = '0, i_interrupt_area_size = '0, i_async_area_size = '0;
   logic [12:0] i_iso_hdr_addr = '0, o_iso_list_b_start, o_interrupt_list_start;
   logic [12:0] o_async_list_start, o_unused_start, o_interrupt_block_addr, o_async_block_addr;
   logic [12:0] o_iso_next_hdr;
   logic [10:0] i_interrupt_block_size = '0, i_async_block_size = '0;
   logic [4:0] i_block_sel = '0;
   logic [9:0] i_iso_total_size = '0;
   logic [15:0][9:0] i_ep_size = '0;
   logic o_data_oe, o_host_dma_request, o_periph_dma_request, o_end_of_transfer;
   logic o_cmd_strobe, o_wr_strobe, o_rd_strobe, o_periph_alloc_ok;
   bus_if_pkg::pin_bus_t i_pins;
   bus_if_pkg::reg_req_t o_req;
   bus_if_pkg::path_t o_path;
   int err_total = 0, n_compared = 0, cyc = 0, n_cmd, n_wr, n_rd, n_oe, n_eot, n_off;
   always #4 i_clk = ~i_clk;
   dual_controller_bus_interface i_dual_controller_bus_interface (.i_clk, .i_rst_n, .i_ce,
      .i_pins, .i_data, .o_data, .o_data_oe, .i_host_dma_want, .i_periph_dma_want,
      .i_host_dma_bytes, .i_periph_dma_bytes, .o_host_dma_request, .o_periph_dma_request,
      .o_end_of_transfer, .i_host_rdata, .i_periph_rdata, .o_req, .o_cmd_strobe, .o_wr_strobe,
      .o_rd_strobe, .o_path, .i_iso_area_size, .i_interrupt_area_size, .i_async_area_size,
      .i_interrupt_block_size, .i_async_block_size, .i_block_sel, .o_iso_list_b_start,
      .o_interrupt_list_start, .o_async_list_start, .o_unused_start, .o_interrupt_block_addr,
      .o_async_block_addr, .i_iso_hdr_addr, .i_iso_total_size, .o_iso_next_hdr,
      .i_ep_configured, .i_ep_size, .o_periph_alloc_ok, .i_direct_mode);
   cpu_dma_model i_cpu_dma_model (.i_clk, .i_dev_data(o_data), .i_dev_oe(o_data_oe),
      .o_pins(i_pins), .o_bus(i_data));
   // ----------------------------------------
   // monitor, timeout and helpers
   // ----------------------------------------
   // pulses are counted here so a one-cycle strobe cannot slip past a task
   always @(posedge i_clk) begin
      cyc++;
      n_cmd += o_cmd_strobe;
      n_wr += o_wr_strobe;
      n_rd += o_rd_strobe;
      n_eot += o_end_of_transfer;
      n_oe += o_data_oe;
      n_off += (o_path === bus_if_pkg::PATH_OFF);
      if (o_data_oe === 1'b1) rd_val = o_data;
      if (cyc == 6000) begin
         err_total++;
         tally_and_finish();
      end
   end
   task automatic check(input logic [79:0] got, exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic xfer(input logic cs_n, a1, a0, rd, ackh, ackp, input logic [15:0] d);
      {n_cmd, n_wr, n_rd, n_oe, n_eot, n_off} = '0;
      rd_val = 16'hxxxx;
      i_cpu_dma_model.access(cs_n, a1, a0, rd, ackh, ackp, d);
   endtask
   function automatic logic [12:0] blk(logic [12:0] s, logic [4:0] n, logic [10:0] b);
      return s + 13'(n) * (13'h0008 + 13'(b));
   endfunction
   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      logic [7:0] idx;
      logic [15:0] w;
      logic [12:0] iso, ia, aa;
      void'($urandom(32'h2a53));
      repeat (6) @(posedge i_clk);
      i_rst_n <= 1'b1;
      repeat (3) @(posedge i_clk);
      // command then two data words, then reads, on both paths
      for (int p = 0; p < 2; p++) begin
         idx = 8'($urandom);
         w = 16'($urandom);
         xfer(1'b0, p[0], 1'b1, 1'b0, 1'b1, 1'b1, {8'h00, idx});
         check(n_cmd, 1);
         check({o_req.periph, o_req.cmd_index}, {p[0], idx});
         for (int k = 0; k < 2; k++) begin
            xfer(1'b0, p[0], 1'b0, 1'b0, 1'b1, 1'b1, w ^ 16'(k));
            check({n_wr, o_req.hi_word, o_req.wdata}, {32'd1, k[0], w ^ 16'(k)});
         end
         i_host_rdata <= p ? ~w : w;
         i_periph_rdata <= p ? w : ~w;
         xfer(1'b0, p[0], 1'b0, 1'b1, 1'b1, 1'b1, '0);
         check({n_rd, rd_val}, {32'd1, w});
         xfer(1'b0, p[0], 1'b1, 1'b1, 1'b1, 1'b1, '0);
         check({n_rd, n_oe}, 0);
      end
      $display("test pio done");
      // host dma write with stray ack and processor priority
      i_host_dma_bytes <= 16'h0004;
      i_host_dma_want <= 1'b1;
      for (int t = 0; t < 20 && o_host_dma_request !== 1'b1; t++) @(posedge i_clk);
      check(o_host_dma_request, 1'b1);
      xfer(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 16'h1111);
      check(n_wr, 0);
      xfer(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 16'h2222);
      check({o_req.periph, o_req.dma}, 2'b10);
      for (int k = 0; k < 2; k++) begin
         xfer(1'b1, k[0], 1'b0, 1'b0, 1'b0, 1'b1, 16'h5a5a ^ 16'(k));
         check({o_req.dma, o_req.periph, o_req.wdata}, {2'b10, 16'h5a5a ^ 16'(k)});
      end
      check({n_eot, o_host_dma_request}, {32'd1, 1'b0});
      // peripheral dma read drives the bus on its ack
      i_host_dma_want <= 1'b0;
      i_periph_rdata <= w;
      i_periph_dma_bytes <= 16'h0002;
      i_periph_dma_want <= 1'b1;
      for (int t = 0; t < 20 && o_periph_dma_request !== 1'b1; t++) @(posedge i_clk);
      xfer(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, '0);
      check({n_rd, n_eot, rd_val}, {32'd1, 32'd1, w});
      i_periph_dma_want <= 1'b0;
      @(posedge i_clk);
      // both channels requested and acknowledged: interface off
      {i_host_dma_bytes, i_periph_dma_bytes} <= {16'h0010, 16'h0010};
      {i_host_dma_want, i_periph_dma_want} <= 2'b11;
      for (int t = 0; t < 20 && !(o_host_dma_request & o_periph_dma_request); t++) @(posedge i_clk);
      xfer(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, '0);
      check({n_off > 0, n_oe, n_rd}, {1'b1, 32'd0, 32'd0});
      {i_host_dma_want, i_periph_dma_want} <= 2'b00;
      $display("test dma done");
      // host buffer layout, first round fills the whole host memory exactly
      for (int r = 0; r < 8; r++) begin
         iso = (r == 0) ? 13'h0400 : 13'($urandom_range(0, 511)) << 1;
         ia = (r == 0) ? 13'h0400 : 13'($urandom_range(0, 511)) << 1;
         aa = (r == 0) ? 13'h0400 : 13'($urandom_range(0, 511)) << 1;
         {i_iso_area_size, i_interrupt_area_size, i_async_area_size} <= {iso, ia, aa};
         i_interrupt_block_size <= 11'($urandom_range(0, 63)) << 2;
         i_async_block_size <= 11'($urandom_range(0, 63)) << 2;
         i_block_sel <= (r == 0) ? 5'd31 : 5'($urandom);
         i_iso_hdr_addr <= 13'($urandom);
         i_iso_total_size <= (r == 0) ? 10'h3fd : 10'($urandom);
         repeat (4) @(posedge i_clk);
         check(o_iso_list_b_start, iso);
         check(o_async_list_start, 13'(2 * iso + ia));
         check(o_interrupt_block_addr, blk(2 * iso, i_block_sel, i_interrupt_block_size));
         check(o_async_block_addr, blk(2 * iso + ia, i_block_sel, i_async_block_size));
      end
      $display("test layout done");
      // peripheral allocation needs every endpoint configured, no direct mode
      for (int e = 0; e < 16; e++) i_ep_size[e] <= 10'($urandom_range(16, 1023));
      i_ep_configured <= 16'hffff;
      repeat (3) @(posedge i_clk);
      check(o_periph_alloc_ok, 1'b1);
      i_ep_configured <= 16'hffff ^ (16'h0001 << $urandom_range(0, 15));
      repeat (3) @(posedge i_clk);
      check(o_periph_alloc_ok, 1'b0);
      i_ep_configured <= 16'hffff;
      i_direct_mode <= 1'b1;
      repeat (3) @(posedge i_clk);
      check(o_periph_alloc_ok, 1'b0);
      $display("test periph done");
      tally_and_finish();
   end
endmodule
